// ===== verilog/tachl_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// Shared constants of the timer channel linking block.
package tachl_pkg;

  // Channel indices: unit 0 channels 0 to 3, then unit 1 channels 0 and 1.
  localparam int NUM_CH      = 6;
  localparam int NUM_PRESC   = 4;
  localparam int PRESC_W     = 15;
  localparam int ADDR_W      = 8;

  // Byte addresses of the registers on the bus.
  localparam logic [7:0] ADDR_FILT_U0   = 8'h00;
  localparam logic [7:0] ADDR_FILT_U1   = 8'h04;
  localparam logic [7:0] ADDR_IN_SWITCH = 8'h08;
  localparam logic [7:0] ADDR_PRESCALE  = 8'h0C;
  localparam logic [7:0] ADDR_MODE_BASE = 8'h10;
  localparam logic [7:0] ADDR_MODE_LAST = 8'h24;
  localparam logic [7:0] ADDR_START     = 8'h28;
  localparam logic [7:0] ADDR_STOP      = 8'h2C;
  localparam logic [7:0] ADDR_STATUS    = 8'h30;

  // Field positions inside a channel mode register.
  localparam int MODE_CKS_LO   = 14;
  localparam int MODE_CKS_HI   = 15;
  localparam int MODE_CCS      = 12;
  localparam int MODE_MS_SPLIT = 11;
  localparam int MODE_LINK     = 8;
  localparam int MODE_IRQ_EN   = 0;

  // Upper-half start, stop and status bits in the start, stop and status words.
  localparam int UPPER_BIT_LO  = 8;

  // Values after reset.
  localparam logic [3:0]  FILT_U0_RST   = 4'h0;
  localparam logic [1:0]  FILT_U1_RST   = 2'h0;
  localparam logic [15:0] PRESCALE_RST  = 16'h0000;
  localparam logic [1:0]  CKS_RST       = 2'h0;

endpackage : tachl_pkg

// ===== verilog/tachl_in_cond.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Input conditioner: synchroniser, optional two-sample filter, rising edge.
module tachl_in_cond
  import tachl_pkg::*;
(
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic reset,
  // Pin and controls.
  input  wire logic pin_in,
  input  wire logic op_tick,
  input  wire logic filter_en,
  // Detected rising edge, one cycle.
  output logic      edge_pulse
);

  logic sync1_r;   // First synchroniser stage, read only by the second.
  logic sync2_r;   // Second synchroniser stage.
  logic samp_r;    // Sample taken on the operation clock.
  logic hist_r;    // Previous operation clock sample.
  logic lvl_r;     // Accepted input level.
  logic lvl_nxt;   // Next accepted level.

  // Two flip-flops bring the pin into the clock domain.
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end
    else
    begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  // A level is accepted directly, or only once two samples agree.
  always_comb
  begin
    lvl_nxt = lvl_r;
    if (!filter_en)
      lvl_nxt = samp_r;
    else if (samp_r == hist_r)
      lvl_nxt = samp_r;
  end

  // Sampling runs on the channel operation clock pulses.
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      samp_r     <= 1'b0;
      hist_r     <= 1'b0;
      lvl_r      <= 1'b0;
      edge_pulse <= 1'b0;
    end
    else
    begin
      edge_pulse <= 1'b0;
      if (op_tick)
      begin
        samp_r     <= sync2_r;
        hist_r     <= samp_r;
        lvl_r      <= lvl_nxt;
        edge_pulse <= lvl_nxt & ~lvl_r;
      end
    end
  end

endmodule : tachl_in_cond

// ===== verilog/tachl_top.sv
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Per-channel filter enable; zero bypasses, one filters.
// - Channel 3 filter follows pin chosen by switch.
// - Filter accepts level stable two operation clocks.
// - Only channel 0 or 2 may be master.
// - Slaves are higher than master, never channel 0.
// - Masters forward irq, start, clock to slaves.
// - Channel 0 master bit reads zero, still master.
// - Split mode only channels 1, 3 of unit 0.
// - Upper half interval only, irq on start.
// - Upper half uses lower half clock select.
// - Upper half has own start, stop, status.
// - Upper bits ignored and kept in 16-bit mode.
// - Split channels take no part in linking.
// - Prescaled count clock, full rate to 2^15.
// - Counter tick one clock after count clock.
// - Pin edge count clock after sampled delay.
// - Started channel waits for sampled rising edge.
module tachl_top
  import tachl_pkg::*;
(
  // Clock and reset.
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  // Avalon-MM register slave.
  input  wire logic [ADDR_W-1:0]    address,
  input  wire logic                 read,
  input  wire logic                 write,
  input  wire logic [31:0]          writedata,
  output logic      [31:0]          readdata,
  output logic                      waitrequest,
  // Timer input pins and serial receive pin.
  input  wire logic [NUM_CH-1:0]    timer_input_pin,
  input  wire logic                 serial_receive_pin,
  // Channel events, one-cycle pulses.
  output logic      [NUM_CH-1:0]    count_tick,
  output logic      [NUM_CH-1:0]    channel_interrupt,
  output logic      [NUM_CH-1:0]    forwarded_interrupt,
  output logic      [1:0]           upper_half_tick,
  output logic      [1:0]           upper_half_interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.

  logic [3:0]        filt_u0_r;        // Filter enables of unit 0 channels.
  logic [1:0]        filt_u1_r;        // Filter enables of unit 1 channels.
  logic              in_switch_r;      // Channel 3 input switch.
  logic [15:0]       presc_sel_r;      // Four 4-bit prescaler divide selects.
  logic [1:0]        cks_r [NUM_CH];   // Operation clock selects.
  logic [NUM_CH-1:0] ccs_r;            // Count clock source per channel.
  logic [NUM_CH-1:0] ms_r;             // Master or split bit per channel.
  logic [NUM_CH-1:0] link_r;           // Slave link bit per channel.
  logic [NUM_CH-1:0] irq_en_r;         // Start interrupt enable per channel.
  logic [NUM_CH-1:0] en_vec;           // Channel enable status.
  logic [1:0]        upper_en_vec;     // Upper-half enable status.
  logic [14:0]       presc_cnt_r;      // Free-running prescaler counter.
  logic [NUM_PRESC-1:0] presc_out;     // Prescaler output pulses.
  logic [NUM_CH-1:0] op_tick;          // Own operation clock per channel.
  logic [NUM_CH-1:0] pin_edge;         // Conditioned pin edge per channel.
  logic [NUM_CH-1:0] filt_vec;         // Filter enable per channel.
  logic [NUM_CH-1:0] irq_nxt;          // Start interrupt next value.
  logic [31:0]       rd_nxt;           // Read data next value.
  logic              acc_wr;           // Write taken this edge.
  logic              mode_hit;         // Address falls on a mode register.
  logic [2:0]        mode_idx;         // Mode register index.
  logic [15:0]       mode_word [NUM_CH];  // Mode register read images.
  logic [NUM_CH-1:0] start_wr;         // Channel start strobes.
  logic [NUM_CH-1:0] stop_wr;          // Channel stop strobes.

  assign filt_vec = {filt_u1_r, filt_u0_r};
  assign acc_wr   = write & ~waitrequest;
  assign mode_hit = (address >= ADDR_MODE_BASE) && (address <= ADDR_MODE_LAST)
                    && (address[1:0] == 2'b00);
  assign mode_idx = 3'((address - ADDR_MODE_BASE) >> 2);
  assign start_wr = (acc_wr && address == ADDR_START) ? writedata[NUM_CH-1:0] : '0;
  assign stop_wr  = (acc_wr && address == ADDR_STOP)  ? writedata[NUM_CH-1:0] : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then the answer at the next edge.

  // Waitrequest drops for one cycle after a request is seen.
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      waitrequest <= 1'b1;
    else if ((read | write) && waitrequest)
      waitrequest <= 1'b0;
    else
      waitrequest <= 1'b1;
  end

  // Read data is prepared while waitrequest is still high.
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      readdata <= 32'h0000_0000;
    else if (read && waitrequest)
      readdata <= rd_nxt;
  end

  // Read multiplexer; unmapped addresses read as zero.
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    if (mode_hit)
      rd_nxt = {16'h0000, mode_word[mode_idx]};
    else
    begin
      case (address)
        ADDR_FILT_U0:   rd_nxt = {28'h000_0000, filt_u0_r};
        ADDR_FILT_U1:   rd_nxt = {30'h0000_0000, filt_u1_r};
        ADDR_IN_SWITCH: rd_nxt = {31'h0000_0000, in_switch_r};
        ADDR_PRESCALE:  rd_nxt = {16'h0000, presc_sel_r};
        ADDR_STATUS:    rd_nxt = {22'h00_0000, upper_en_vec, 2'b00, en_vec};
        default:        rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers written by software.

  // Filter enables, input switch and prescaler selects.
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      filt_u0_r   <= FILT_U0_RST;
      filt_u1_r   <= FILT_U1_RST;
      in_switch_r <= 1'b0;
      presc_sel_r <= PRESCALE_RST;
    end
    else if (acc_wr)
    begin
      case (address)
        ADDR_FILT_U0:   filt_u0_r   <= writedata[3:0];
        ADDR_FILT_U1:   filt_u1_r   <= writedata[1:0];
        ADDR_IN_SWITCH: in_switch_r <= writedata[0];
        ADDR_PRESCALE:  presc_sel_r <= writedata[15:0];
        default:        presc_sel_r <= presc_sel_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: each output pulses once per 2^k clocks, k = 0 holds high.

  // The counter runs without stopping.
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      presc_cnt_r <= 15'h0000;
    else
      presc_cnt_r <= presc_cnt_r + 15'h0001;
  end

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PRESC; gp++)
    begin : g_presc
      logic [3:0]  div_sel;   // Divide exponent of this output.
      logic [14:0] mask;      // Low counter bits that must all be one.
      assign div_sel = presc_sel_r[4*gp +: 4];
      assign mask    = 15'((16'h0001 << div_sel) - 16'h0001);
      // Zero exponent leaves the mask empty, so the output stays high.
      assign presc_out[gp] = ((presc_cnt_r & mask) == mask);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Channels.

  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc++)
    begin : g_ch
      // Channel 0 of each unit is always master; channel 2 of unit 0 may be.
      localparam bit FIXED_MASTER = (gc == 0) || (gc == 4);
      localparam bit CAN_MASTER   = (gc == 2);
      localparam bit CAN_SPLIT    = (gc == 1) || (gc == 3);
      logic        is_master;   // This channel heads a group.
      logic        split;       // Split 8-bit operation is active.
      logic        linked;      // This channel follows a master.
      int          mst;         // Index of the governing master.
      logic        eff_tick;    // Operation clock used for counting.
      logic        cclk;        // Count clock of this channel.
      logic        start_nxt;   // Start trigger including forwarded start.
      logic        pend_r;      // Waiting for first count clock.
      logic        en_r;        // Channel enabled.
      logic        tick_r;      // Counter update pulse.
      logic        irq_r;       // Start interrupt pulse.
      logic        fwd_r;       // Interrupt forwarded from the master.
      logic        pin_sel;     // Selected input pin.

      assign is_master = FIXED_MASTER || (CAN_MASTER && ms_r[gc]);
      assign split     = CAN_SPLIT && ms_r[gc];
      assign linked    = link_r[gc] && !is_master && !split;
      assign mst       = (gc >= 4) ? 4 : ((gc == 3 && ms_r[2]) ? 2 : 0);
      assign op_tick[gc] = presc_out[cks_r[gc]];
      assign eff_tick  = linked ? op_tick[mst] : op_tick[gc];
      assign cclk      = ccs_r[gc] ? pin_edge[gc] : eff_tick;
      assign start_nxt = start_wr[gc] || (linked && start_wr[mst]);
      assign pin_sel   = (gc == 3 && in_switch_r) ? serial_receive_pin
                                                  : timer_input_pin[gc];
      assign en_vec[gc] = en_r;
      assign irq_nxt[gc] = en_r && pend_r && cclk && irq_en_r[gc] && !ccs_r[gc];
      assign count_tick[gc]          = tick_r;
      assign channel_interrupt[gc]   = irq_r;
      assign forwarded_interrupt[gc] = fwd_r;

      // Pin conditioning on the channel's own operation clock.
      tachl_in_cond u_in_cond (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .pin_in     (pin_sel),
        .op_tick    (op_tick[gc]),
        .filter_en  (filt_vec[gc]),
        .edge_pulse (pin_edge[gc])
      );

      // Mode register fields; fixed bits are not stored.
      always_ff @(posedge ref_clk or posedge reset)
      begin
        if (reset)
        begin
          cks_r[gc]    <= CKS_RST;
          ccs_r[gc]    <= 1'b0;
          ms_r[gc]     <= 1'b0;
          link_r[gc]   <= 1'b0;
          irq_en_r[gc] <= 1'b0;
        end
        else if (acc_wr && mode_hit && mode_idx == 3'(gc))
        begin
          cks_r[gc]    <= writedata[MODE_CKS_HI:MODE_CKS_LO];
          ccs_r[gc]    <= writedata[MODE_CCS];
          ms_r[gc]     <= (CAN_MASTER || CAN_SPLIT) && writedata[MODE_MS_SPLIT];
          link_r[gc]   <= !FIXED_MASTER && writedata[MODE_LINK];
          irq_en_r[gc] <= writedata[MODE_IRQ_EN];
        end
      end

      assign mode_word[gc] = {cks_r[gc], 1'b0, ccs_r[gc], ms_r[gc], 2'b00, link_r[gc],
                              7'h00, irq_en_r[gc]};

      // Start sets enable and arms the start trigger; stop clears both.
      always_ff @(posedge ref_clk or posedge reset)
      begin
        if (reset)
        begin
          en_r   <= 1'b0;
          pend_r <= 1'b0;
        end
        else if (start_nxt)
        begin
          en_r   <= 1'b1;
          pend_r <= 1'b1;
        end
        else if (stop_wr[gc])
        begin
          en_r   <= 1'b0;
          pend_r <= 1'b0;
        end
        else if (en_r && cclk)
          pend_r <= 1'b0;
      end

      // Counter update, start interrupt and forwarded interrupt pulses.
      always_ff @(posedge ref_clk or posedge reset)
      begin
        if (reset)
        begin
          tick_r <= 1'b0;
          irq_r  <= 1'b0;
          fwd_r  <= 1'b0;
        end
        else
        begin
          tick_r <= en_r && cclk;
          irq_r  <= irq_nxt[gc];
          fwd_r  <= linked && irq_nxt[mst];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Upper 8-bit halves of channels 1 and 3 of unit 0.

  genvar gu;
  generate
    for (gu = 0; gu < 2; gu++)
    begin : g_upper
      localparam int CH = 2 * gu + 1;
      logic up_en_r;    // Upper half running.
      logic up_tick_r;  // Upper half interval tick.
      logic up_irq_r;   // Upper half start interrupt.
      logic up_start;   // Upper start strobe, honoured only when split.
      logic up_stop;    // Upper stop strobe, honoured only when split.

      assign up_start = acc_wr && address == ADDR_START && writedata[UPPER_BIT_LO + gu]
                        && ms_r[CH];
      assign up_stop  = acc_wr && address == ADDR_STOP && writedata[UPPER_BIT_LO + gu]
                        && ms_r[CH];
      assign upper_en_vec[gu]         = up_en_r;
      assign upper_half_tick[gu]      = up_tick_r;
      assign upper_half_interrupt[gu] = up_irq_r;

      // Upper half status; it keeps its value in 16-bit mode.
      always_ff @(posedge ref_clk or posedge reset)
      begin
        if (reset)
          up_en_r <= 1'b0;
        else if (up_start)
          up_en_r <= 1'b1;
        else if (up_stop)
          up_en_r <= 1'b0;
      end

      // Interval ticks on the lower half's operation clock.
      always_ff @(posedge ref_clk or posedge reset)
      begin
        if (reset)
        begin
          up_tick_r <= 1'b0;
          up_irq_r  <= 1'b0;
        end
        else
        begin
          up_tick_r <= up_en_r && ms_r[CH] && op_tick[CH];
          up_irq_r  <= up_start;
        end
      end
    end
  endgenerate

endmodule : tachl_top

// ===== tb/tachl_sva.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
// Port checks on the register bus and the event pulses.
module tachl_sva
  import tachl_pkg::*;
(
  // Clock and reset.
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // Register bus.
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [31:0]       readdata,
  input  wire logic              waitrequest,
  // Events.
  input  wire logic [NUM_CH-1:0] channel_interrupt,
  input  wire logic [NUM_CH-1:0] forwarded_interrupt,
  input  wire logic [1:0]        upper_half_interrupt
);
  // One clock domain, so one clocking and one disable.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  a_req_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  a_wait_one: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_cause: assert property ($fell(waitrequest) |-> $past(read || write))
    else $error("answer without a request");
  a_unmapped_zero: assert property (read && !waitrequest && address > ADDR_STATUS |-> readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_rd_hold: assert property (!read |=> $stable(readdata))
    else $error("read data moved without a read");
  a_uhi1_cause: assert property (upper_half_interrupt[0]
    |-> $past(write && !waitrequest && address == ADDR_START && writedata[UPPER_BIT_LO]))
    else $error("upper interrupt of channel 1 without a start write");
  a_uhi3_cause: assert property (upper_half_interrupt[1]
    |-> $past(write && !waitrequest && address == ADDR_START && writedata[UPPER_BIT_LO+1]))
    else $error("upper interrupt of channel 3 without a start write");
  a_uhi_pulse: assert property (upper_half_interrupt[0] |=> !upper_half_interrupt[0])
    else $error("upper interrupt longer than one cycle");
  a_irq_once: assert property (channel_interrupt[0] |=> !channel_interrupt[0])
    else $error("start interrupt longer than one cycle");
  a_fwd_master: assert property (forwarded_interrupt[0] == 1'b0 && forwarded_interrupt[4] == 1'b0)
    else $error("master channel received a forwarded interrupt");
  a_fwd_follow: assert property (forwarded_interrupt[1] |-> channel_interrupt[0])
    else $error("forwarded interrupt without a master interrupt");

  // Main scenarios reached.
  c_read: cover property (read && !waitrequest);
  c_uhi: cover property (upper_half_interrupt[0]);
  c_fwd: cover property (forwarded_interrupt[1]);
endmodule : tachl_sva

bind tachl_top tachl_sva u_sva (.ref_clk, .reset, .address, .read, .write, .writedata, .readdata,
  .waitrequest, .channel_interrupt, .forwarded_interrupt, .upper_half_interrupt);

// ===== tb/tachl_pins.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
// Pin side: timer inputs idle low, serial receive idles high.
module tachl_pins
  import tachl_pkg::*;
(
  // Clock.
  input  wire logic              ref_clk,
  // Lines toward the block.
  output logic      [NUM_CH-1:0] pin,
  output logic                   rxd
);
  // Idle levels from time zero; all lines are inputs to the block.
  initial
  begin
    pin = '0;
    rxd = 1'b1;
  end

  // Inverts one line for width cycles; index NUM_CH is the serial line.
  task automatic pulse(input int idx, input int width);
    @(posedge ref_clk);
    if (idx == NUM_CH)
      rxd <= ~rxd;
    else
      pin[idx] <= ~pin[idx];
    repeat (width) @(posedge ref_clk);
    if (idx == NUM_CH)
      rxd <= ~rxd;
    else
      pin[idx] <= ~pin[idx];
  endtask : pulse
endmodule : tachl_pins

// ===== tb/tb_top.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
// Self-checking bench of the timer channel linking block.
module tb_top
  import tachl_pkg::*;
;
  logic              ref_clk;      // Bench clock, 50 MHz.
  logic              reset;        // Asynchronous reset.
  logic [ADDR_W-1:0] address;      // Bus address.
  logic              read;         // Bus read.
  logic              write;        // Bus write.
  logic [31:0]       writedata;    // Bus write data.
  logic [31:0]       readdata;     // Bus read data.
  logic              waitrequest;  // Bus wait.
  logic [NUM_CH-1:0] pin;          // Timer input lines.
  logic              rxd;          // Serial receive line.
  logic [NUM_CH-1:0] tick;         // Counter updates.
  logic [NUM_CH-1:0] irq;          // Start interrupts.
  logic [NUM_CH-1:0] fwd;          // Forwarded interrupts.
  logic [1:0]        uh_tick;      // Upper half ticks.
  logic [1:0]        uh_irq;       // Upper half interrupts.
  logic [21:0]       ev;           // All events, one vector.
  int                n_fail;       // Mismatches.
  int                num_checks;   // Comparisons.

  assign ev = {uh_irq, uh_tick, fwd, irq, tick};

  tachl_top uut (.ref_clk(ref_clk), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .timer_input_pin(pin),
    .serial_receive_pin(rxd), .count_tick(tick), .channel_interrupt(irq), .forwarded_interrupt(fwd),
    .upper_half_tick(uh_tick), .upper_half_interrupt(uh_irq));
  tachl_pins u_pins (.ref_clk(ref_clk), .pin(pin), .rxd(rxd));

  // Clock generator.
  always #10 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task summarize;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  // Compares one value.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h got %h", nm, e, g);
    end
  endtask : chk

  // Bus cycle: held until waitrequest is sampled low, then released.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int t;
    t = 0;
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    do
    begin
      @(posedge ref_clk);
      t++;
    end
    while (waitrequest !== 1'b0 && t < 20);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (t >= 20)
      n_fail++;
    @(posedge ref_clk);
  endtask : bus

  // Write helpers.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic wr_mode(input int c, input logic [31:0] d);
    wr(ADDR_MODE_BASE + 8'(4 * c), d);
  endtask : wr_mode

  // Reads a register and compares it.
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(nm, e, q);
  endtask : rd_chk

  // Counts pulses of one event over a window and compares the count.
  task automatic cnt_chk(input string nm, input int idx, input int cyc, input int e);
    int n;
    n = 0;
    repeat (cyc)
    begin
      @(posedge ref_clk);
      if (ev[idx] === 1'b1)
        n++;
    end
    chk(nm, 32'(e), 32'(n));
  endtask : cnt_chk

  ////////////////////////////////////////////////////////////
  // Reset values, field widths, unmapped place, master and split bits.
  task automatic t_regs;
    rd_chk("filt_u0", ADDR_FILT_U0, 32'(FILT_U0_RST));
    rd_chk("filt_u1", ADDR_FILT_U1, 32'(FILT_U1_RST));
    rd_chk("presc", ADDR_PRESCALE, 32'(PRESCALE_RST));
    rd_chk("status", ADDR_STATUS, 32'h0000_0000);
    wr(ADDR_FILT_U0, 32'hFFFF_FFFF);
    rd_chk("filt_u0_all", ADDR_FILT_U0, 32'h0000_000F);
    wr(ADDR_FILT_U1, 32'hFFFF_FFFF);
    rd_chk("filt_u1_all", ADDR_FILT_U1, 32'h0000_0003);
    wr(8'h40, 32'hFFFF_FFFF);
    rd_chk("unmapped", 8'h40, 32'h0000_0000);
    for (int c = 0; c < NUM_CH; c++)
    begin
      wr_mode(c, 32'h0000_0800);
      rd_chk("mode_bit11", ADDR_MODE_BASE + 8'(4 * c), (c >= 1 && c <= 3) ? 32'h0000_0800 : 32'h0000_0000);
      wr_mode(c, 32'h0000_0000);
    end
    wr(ADDR_FILT_U0, 32'h0000_0000);
    wr(ADDR_FILT_U1, 32'h0000_0000);
  endtask : t_regs

  // Prescaled count clock at full rate and at a quarter rate.
  task automatic t_presc;
    wr_mode(0, 32'h0000_0001);
    fork
      wr(ADDR_START, 32'h0000_0001);
      cnt_chk("irq0", 6, 10, 1);
    join
    cnt_chk("tick0_full", 0, 16, 16);
    wr(ADDR_STOP, 32'h0000_0001);
    wr(ADDR_PRESCALE, 32'h0000_0002);
    fork
      wr(ADDR_START, 32'h0000_0001);
      cnt_chk("irq0_k2", 6, 12, 1);
    join
    cnt_chk("tick0_k2", 0, 32, 8);
    wr(ADDR_STOP, 32'h0000_0001);
    cnt_chk("tick0_off", 0, 8, 0);
  endtask : t_presc

  // Split channel 1 upper half, then upper bits of unsplit channel 3.
  task automatic t_split;
    wr_mode(1, 32'h0000_0800);
    fork
      wr(ADDR_START, 32'h0000_0100);
      cnt_chk("uhi1", 20, 6, 1);
    join
    rd_chk("status_up1", ADDR_STATUS, 32'h0000_0100);
    cnt_chk("uht1", 18, 32, 8);
    wr(ADDR_STOP, 32'h0000_0100);
    rd_chk("status_up1_off", ADDR_STATUS, 32'h0000_0000);
    fork
      wr(ADDR_START, 32'h0000_0200);
      cnt_chk("uhi3", 21, 6, 0);
    join
    rd_chk("status_up3", ADDR_STATUS, 32'h0000_0000);
  endtask : t_split

  // Pin edges as count clock, filter, and serial pin for channel 3.
  task automatic t_pin;
    wr(ADDR_PRESCALE, 32'h0000_0000);
    wr_mode(2, 32'h0000_1000);
    wr(ADDR_START, 32'h0000_0004);
    fork
      u_pins.pulse(2, 2);
      cnt_chk("pin2", 2, 16, 1);
    join
    wr(ADDR_FILT_U0, 32'h0000_0004);
    fork
      u_pins.pulse(2, 1);
      cnt_chk("glitch2", 2, 16, 0);
    join
    fork
      u_pins.pulse(2, 4);
      cnt_chk("filt2", 2, 16, 1);
    join
    wr(ADDR_IN_SWITCH, 32'h0000_0001);
    wr_mode(3, 32'h0000_1000);
    wr(ADDR_START, 32'h0000_0008);
    fork
      u_pins.pulse(3, 4);
      cnt_chk("pin3_off", 3, 16, 0);
    join
    fork
      u_pins.pulse(NUM_CH, 4);
      cnt_chk("rx3", 3, 16, 1);
    join
    wr(ADDR_FILT_U0, 32'h0000_0008);
    fork
      u_pins.pulse(NUM_CH, 1);
      cnt_chk("rx3_glitch", 3, 16, 0);
    join
    wr(ADDR_STOP, 32'h0000_003F);
    wr(ADDR_FILT_U0, 32'h0000_0000);
    wr(ADDR_IN_SWITCH, 32'h0000_0000);
    wr_mode(2, 32'h0000_0000);
    wr_mode(3, 32'h0000_0000);
  endtask : t_pin

  // Master and slave groups, all on clock select 0.
  task automatic t_link;
    wr_mode(1, 32'h0000_0900);
    wr(ADDR_START, 32'h0000_0001);
    rd_chk("split_nolink", ADDR_STATUS, 32'h0000_0001);
    wr(ADDR_STOP, 32'h0000_0001);
    wr_mode(1, 32'h0000_0100);
    wr_mode(2, 32'h0000_0800);
    wr_mode(3, 32'h0000_0100);
    wr_mode(5, 32'h0000_0100);
    fork
      wr(ADDR_START, 32'h0000_0001);
      cnt_chk("fwd1", 13, 10, 1);
    join
    rd_chk("group0", ADDR_STATUS, 32'h0000_0003);
    wr(ADDR_START, 32'h0000_0004);
    rd_chk("group2", ADDR_STATUS, 32'h0000_000F);
    wr(ADDR_START, 32'h0000_0010);
    rd_chk("group_u1", ADDR_STATUS, 32'h0000_003F);
    wr(ADDR_STOP, 32'h0000_003F);
    rd_chk("all_off", ADDR_STATUS, 32'h0000_0000);
  endtask : t_link

  ////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    ref_clk = 1'b0;
    reset = 1'b1;
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    n_fail = 0;
    num_checks = 0;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_presc();
    t_split();
    t_pin();
    t_link();
    summarize();
  end

  // Watchdog against a hung handshake.
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    summarize();
  end
endmodule : tb_top
